// ---- hdl/mgmt_regs_pkg.sv ----
package mgmt_regs_pkg;
  // register offsets on the management bus
  localparam logic [4:0] off_access_control = 5'h0d;
  localparam logic [4:0] off_window = 5'h0e;
  localparam logic [4:0] off_capability = 5'h0f;
  localparam logic [4:0] off_general_control = 5'h10;
  // reset values
  localparam logic [15:0] access_control_reset = 16'h0000;
  localparam logic [15:0] window_reset = 16'h0000;
  localparam logic [15:0] capability_value = 16'hf000;
  localparam logic [15:0] general_control_reset = 16'h5048;
  // field positions and values
  localparam int func_hi = 15;
  localparam int func_lo = 14;
  localparam int devsel_hi = 4;
  localparam int devsel_lo = 0;
  localparam logic [1:0] func_address = 2'h0;
  localparam logic [1:0] func_data = 2'h1;
  localparam logic [1:0] func_inc_rw = 2'h2;
  localparam logic [1:0] func_inc_wr = 2'h3;
  localparam logic [4:0] vendor_mmd = 5'h1f;
  localparam logic [1:0] speed_1g = 2'h2;
  localparam logic [1:0] xover_mdi = 2'h0;
  localparam logic [1:0] xover_mdix = 2'h1;
  localparam logic [1:0] power_normal = 2'h0;
  localparam logic [1:0] power_active_sleep = 2'h2;
  localparam logic [1:0] power_passive_sleep = 2'h3;
  // elastic fifo depth for each code
  localparam logic [3:0] depth_code0 = 4'h3;
  localparam logic [3:0] depth_code1 = 4'h4;
  localparam logic [3:0] depth_code2 = 4'h6;
  localparam logic [3:0] depth_code3 = 4'h8;
  // frame counts in management clock bits; strap settle in clock cycles; opcodes
  localparam logic [5:0] preamble_bits = 6'd32;
  localparam logic [4:0] header_bits = 5'd13;
  localparam logic [4:0] turnaround_bits = 5'd2;
  localparam logic [4:0] data_bits = 5'd16;
  localparam logic [1:0] strap_settle = 2'd3;
  localparam logic [1:0] op_write = 2'h1;
  localparam logic [1:0] op_read = 2'h2;

  typedef struct packed {
    logic [1:0] tx_depth;
    logic [1:0] rx_depth;
    logic rsvd11;
    logic force_link;
    logic [1:0] power_save;
    logic rsvd7;
    logic [1:0] crossover_select;
    logic clock_out_off;
    logic [1:0] rsvd3_2;
    logic line_drive_invert;
    logic jabber_off;
  } general_control_t;

  typedef enum logic [2:0] {
    st_preamble = 3'b000,
    st_header = 3'b001,
    st_turn = 3'b010,
    st_data = 3'b011,
    st_skip = 3'b100
  } frame_state_t;
endpackage

// ---- hdl/phy_mgmt_regs.sv ----
// Contract
// - device-select field routes every window access to the chosen MMD.
// - function bits 15-14 pick address, data, inc rw, inc write-only.
// - window reaches MMD address register for function 00, else data.
// - capability register reads four ability flags, all one after reset.
// - tx fifo active gig copper GMII or SGMII; depths 3,4,6,8; reset 1.
// - rx fifo active only with SGMII; same depth codes; reset 1.
// - forced-link bit reports link good when speed is 1G.
// - power field: normal, reserved, active sleep, passive sleep; reset normal.
// - crossover: 0 MDI, 1 MDI-X, else automatic; reset from strap.
// - line-drive invert bit inverts transmission except in mirror mode.
// - jabber-disable bit turns jabber function off when set.
`timescale 1ns/100ps
module phy_mgmt_regs
  import mgmt_regs_pkg::*;
#(
  parameter logic [4:0] phy_addr = 5'h00,
  parameter int mmd_count = 32
)(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [1:0] crossover_strap,
  input wire logic [1:0] op_speed,
  input wire logic sgmii_sel,
  input wire logic copper_sel,
  input wire logic link_qualified,
  input wire logic mirror_mode,
  output logic [4:0] ext_dev,
  output logic [15:0] ext_addr,
  output logic [15:0] ext_wdata,
  output logic ext_wr,
  output logic ext_rd,
  input wire logic [15:0] ext_rdata,
  output logic tx_fifo_enable,
  output logic [3:0] tx_fifo_depth,
  output logic rx_fifo_enable,
  output logic [3:0] rx_fifo_depth,
  output logic link_good,
  output logic active_sleep,
  output logic passive_sleep,
  output logic force_mdi,
  output logic force_mdix,
  output logic auto_crossover,
  output logic ref_clock_output,
  output logic line_drive_invert,
  output logic jabber_enable
);
  import mgmt_regs_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] mdc_s_q;
  logic [2:0] mdio_s_q;
  logic mdc_lvl_q;
  logic mdc_rise;
  logic mdc_fall;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mdc_s_q <= 3'h0;
      mdio_s_q <= 3'h0;
      mdc_lvl_q <= 1'b0;
    end
    else
    begin
      mdc_s_q <= {mdc_s_q[1:0], mdc};
      mdio_s_q <= {mdio_s_q[1:0], mdio_in};
      if (mdc_s_q[1] == mdc_s_q[2])
        mdc_lvl_q <= mdc_s_q[2];
    end
  end

  assign mdc_rise = (mdc_s_q[1] == mdc_s_q[2]) && mdc_s_q[2] && !mdc_lvl_q;
  assign mdc_fall = (mdc_s_q[1] == mdc_s_q[2]) && !mdc_s_q[2] && mdc_lvl_q;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [1:0] func_q;
  logic [4:0] devsel_q;
  general_control_t ctrl_q;
  logic [15:0] mmd_addr_q [mmd_count];
  logic [1:0] strap_cnt_q;
  logic [15:0] ctrl_word;

  assign ctrl_word = ctrl_q;

  // ----------------------------------------
  // frame decoder
  // ----------------------------------------
  frame_state_t state_q;
  logic [5:0] cnt_q;
  logic [12:0] hdr_q;
  logic [15:0] sh_q;
  logic is_read_q;
  logic win_data;
  logic [4:0] regad;
  logic hdr_ok;
  logic hdr_read;
  logic frame_done;
  logic [15:0] local_rdata;
  logic post_inc_rd;
  logic post_inc_wr;

  assign regad = hdr_q[4:0];
  assign hdr_ok = hdr_q[12] && (hdr_q[9:5] == phy_addr);
  assign hdr_read = hdr_q[11:10] == op_read;
  assign frame_done = mdc_rise && state_q == st_data && cnt_q == 6'(data_bits - 5'd1);
  assign win_data = func_q != func_address;
  assign post_inc_rd = func_q == func_inc_rw;
  assign post_inc_wr = func_q == func_inc_rw || func_q == func_inc_wr;

  always_comb
  begin
    local_rdata = 16'h0000;
    case (regad)
      off_access_control: local_rdata = {func_q, 9'h000, devsel_q};
      off_window: local_rdata = mmd_addr_q[devsel_q];
      off_capability: local_rdata = capability_value;
      off_general_control: local_rdata = ctrl_word;
      default: local_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= st_preamble;
      cnt_q <= 6'd0;
      hdr_q <= 13'h0000;
      is_read_q <= 1'b0;
    end
    else if (mdc_rise)
    begin
      case (state_q)
        st_preamble:
          if (mdio_s_q[2])
            cnt_q <= (cnt_q == preamble_bits) ? cnt_q : cnt_q + 6'd1;
          else if (cnt_q == preamble_bits)
          begin
            state_q <= st_header;
            cnt_q <= 6'd0;
          end
          else
            cnt_q <= 6'd0;
        st_header:
        begin
          hdr_q <= {hdr_q[11:0], mdio_s_q[2]};
          cnt_q <= cnt_q + 6'd1;
          if (cnt_q == 6'(header_bits - 5'd1))
          begin
            state_q <= st_turn;
            cnt_q <= 6'd0;
          end
        end
        st_turn:
        begin
          is_read_q <= hdr_ok && hdr_read;
          cnt_q <= cnt_q + 6'd1;
          if (cnt_q == 6'(turnaround_bits - 5'd1))
          begin
            state_q <= st_data;
            cnt_q <= 6'd0;
          end
        end
        st_data:
        begin
          cnt_q <= cnt_q + 6'd1;
          if (cnt_q == 6'(data_bits - 5'd1))
          begin
            state_q <= st_preamble;
            cnt_q <= 6'd0;
            is_read_q <= 1'b0;
          end
        end
        default:
          state_q <= st_preamble;
      endcase
    end
  end

  // header just completed this cycle: one-cycle strobe
  logic hdr_done;
  assign hdr_done = mdc_rise && state_q == st_header && cnt_q == 6'(header_bits - 5'd1);
  // hdr_q still lacks its last bit while hdr_done is high
  logic [12:0] hdr_full;
  assign hdr_full = {hdr_q[11:0], mdio_s_q[2]};
  logic hdr_seen_q;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      hdr_seen_q <= 1'b0;
    else
      hdr_seen_q <= hdr_done;
  end

  // ----------------------------------------
  // read shifter and mdio drive
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sh_q <= 16'h0000;
      mdio_out <= 1'b1;
      mdio_oe <= 1'b0;
    end
    else if (ext_rd)
      sh_q <= ext_rdata;
    else if (hdr_seen_q)
      sh_q <= local_rdata;
    else if (mdc_rise && state_q == st_data && !is_read_q)
      sh_q <= {sh_q[14:0], mdio_s_q[2]};
    else if (mdc_fall)
    begin
      if (state_q == st_turn && cnt_q == 6'd1 && is_read_q)
      begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
      end
      else if (state_q == st_data && is_read_q)
      begin
        mdio_out <= sh_q[15];
        sh_q <= {sh_q[14:0], 1'b0};
      end
      else
      begin
        mdio_oe <= 1'b0;
        mdio_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // register writes and window routing
  // ----------------------------------------
  logic wr_frame;
  logic [15:0] wdata;
  assign wr_frame = frame_done && !is_read_q && hdr_ok && hdr_q[11:10] == op_write;
  assign wdata = {sh_q[14:0], mdio_s_q[2]};

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      func_q <= access_control_reset[func_hi:func_lo];
      devsel_q <= access_control_reset[devsel_hi:devsel_lo];
      ctrl_q <= general_control_reset;
      strap_cnt_q <= 2'd0;
      ext_dev <= 5'h00;
      ext_addr <= window_reset;
      ext_wdata <= window_reset;
      ext_wr <= 1'b0;
      ext_rd <= 1'b0;
    end
    else
    begin
      ext_wr <= 1'b0;
      ext_rd <= 1'b0;
      // strap taken once the pin has settled after release
      if (strap_cnt_q != strap_settle)
      begin
        strap_cnt_q <= strap_cnt_q + 2'd1;
        if (strap_cnt_q == strap_settle - 2'd1)
          ctrl_q.crossover_select <= crossover_strap;
      end
      // data reads routed to selected device
      if (hdr_done && hdr_full[12] && hdr_full[9:5] == phy_addr && hdr_full[11:10] == op_read
          && hdr_full[4:0] == off_window && win_data)
      begin
        ext_rd <= 1'b1;
        ext_dev <= devsel_q;
        ext_addr <= mmd_addr_q[devsel_q];
      end
      if (wr_frame)
        case (regad)
          off_access_control:
          begin
            func_q <= wdata[func_hi:func_lo];
            devsel_q <= wdata[devsel_hi:devsel_lo];
          end
          off_window:
            if (win_data)
            begin
              // data writes routed to selected device
              ext_wr <= 1'b1;
              ext_dev <= devsel_q;
              ext_addr <= mmd_addr_q[devsel_q];
              ext_wdata <= wdata;
            end
          off_general_control: ctrl_q <= wdata;
          default: ;
        endcase
    end
  end

  // per-device address registers; array left without reset to stay a plain memory
  always_ff @(posedge clock)
  begin
    if (wr_frame && regad == off_window && !win_data)
      mmd_addr_q[devsel_q] <= wdata;
    else if (wr_frame && regad == off_window && post_inc_wr)
      mmd_addr_q[devsel_q] <= mmd_addr_q[devsel_q] + 16'h0001;
    else if (ext_rd && post_inc_rd)
      mmd_addr_q[devsel_q] <= mmd_addr_q[devsel_q] + 16'h0001;
  end

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  function automatic logic [3:0] depth_of(input logic [1:0] code);
    case (code)
      2'h0: depth_of = depth_code0;
      2'h1: depth_of = depth_code1;
      2'h2: depth_of = depth_code2;
      default: depth_of = depth_code3;
    endcase
  endfunction

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_fifo_enable <= 1'b0;
      tx_fifo_depth <= depth_code1;
      rx_fifo_enable <= 1'b0;
      rx_fifo_depth <= depth_code1;
      link_good <= 1'b0;
      active_sleep <= 1'b0;
      passive_sleep <= 1'b0;
      force_mdi <= 1'b0;
      force_mdix <= 1'b0;
      auto_crossover <= 1'b1;
      ref_clock_output <= 1'b1;
      line_drive_invert <= 1'b0;
      jabber_enable <= 1'b1;
    end
    else
    begin
      // tx fifo mode gating and depth
      tx_fifo_enable <= copper_sel && (sgmii_sel || op_speed == speed_1g);
      tx_fifo_depth <= depth_of(ctrl_q.tx_depth);
      rx_fifo_enable <= sgmii_sel;
      rx_fifo_depth <= depth_of(ctrl_q.rx_depth);
      link_good <= link_qualified || (ctrl_q.force_link && op_speed == speed_1g);
      // power-save decode, reserved code acts as normal
      active_sleep <= ctrl_q.power_save == power_active_sleep;
      passive_sleep <= ctrl_q.power_save == power_passive_sleep;
      force_mdi <= ctrl_q.crossover_select == xover_mdi;
      force_mdix <= ctrl_q.crossover_select == xover_mdix;
      auto_crossover <= ctrl_q.crossover_select[1];
      ref_clock_output <= !ctrl_q.clock_out_off;
      line_drive_invert <= ctrl_q.line_drive_invert && !mirror_mode;
      jabber_enable <= !ctrl_q.jabber_off;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_wr_window_data;
    wr_frame && regad == off_window && win_data;
  endsequence

  a_window_write_route: assert property (@(posedge clock) disable iff (!rst_b)
    s_wr_window_data |=> ext_wr && ext_dev == $past(devsel_q) && ext_wdata == $past(wdata))
    else $error("window data write not routed");
  a_window_read_route: assert property (@(posedge clock) disable iff (!rst_b)
    (hdr_seen_q && hdr_ok && hdr_read && regad == off_window && win_data) |-> ext_rd && ext_dev == devsel_q)
    else $error("window data read not routed");
  a_address_no_ext: assert property (@(posedge clock) disable iff (!rst_b)
    (wr_frame && regad == off_window && !win_data) |=> !ext_wr && mmd_addr_q[$past(devsel_q)] == $past(wdata))
    else $error("address phase misrouted");
  a_postinc_write: assert property (@(posedge clock) disable iff (!rst_b)
    (s_wr_window_data and post_inc_wr) |=> mmd_addr_q[devsel_q] == ext_addr + 16'h0001)
    else $error("post increment missing");
  a_no_inc_plain: assert property (@(posedge clock) disable iff (!rst_b)
    (s_wr_window_data and func_q == func_data) |=> mmd_addr_q[devsel_q] == ext_addr)
    else $error("plain data access moved address");
  a_forced_link: assert property (@(posedge clock) disable iff (!rst_b)
    (ctrl_q.force_link && op_speed == speed_1g) |=> link_good)
    else $error("forced link not reported");
  a_rx_fifo_gate: assert property (@(posedge clock) disable iff (!rst_b)
    !sgmii_sel |=> !rx_fifo_enable)
    else $error("rx fifo active without sgmii");
  a_tx_depth_map: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_q.tx_depth == 2'h2 |=> tx_fifo_depth == 4'h6)
    else $error("tx depth code mismatch");
  a_mirror_invert: assert property (@(posedge clock) disable iff (!rst_b)
    mirror_mode |=> !line_drive_invert)
    else $error("invert active in mirror mode");
  a_clock_gate: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_q.clock_out_off |=> !ref_clock_output)
    else $error("clock output not stopped");
  a_jabber_off: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_q.jabber_off |=> !jabber_enable)
    else $error("jabber not disabled");
  a_sleep_decode: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_q.power_save == power_normal |=> !active_sleep && !passive_sleep)
    else $error("sleep in normal mode");
  a_auto_xover: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_q.crossover_select[1] |=> auto_crossover && !force_mdi && !force_mdix)
    else $error("crossover decode wrong");
  a_capability_read: assert property (@(posedge clock) disable iff (!rst_b)
    (hdr_seen_q && regad == off_capability) |=> sh_q == capability_value)
    else $error("capability read wrong");
endmodule

// ---- bench/mdio_station.sv ----
`timescale 1ns/100ps
module mdio_station
  import mgmt_regs_pkg::*;
(
  input wire logic clock,
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  logic st_oe;
  logic st_val;
  // ----------------------------------------
  // wire level: pull-up wins when nobody drives
  // ----------------------------------------
  assign mdio_in = mdio_oe ? mdio_out : (st_oe ? st_val : 1'b1);
  initial
  begin
    mdc = 1'b0;
    st_oe = 1'b0;
    st_val = 1'b1;
  end
  // data set in low phase, sampled late in high phase; 4 clocks per phase keeps the sync margin
  task automatic bit_cycle(input logic drive, input logic b, output logic s);
    st_oe <= drive;
    st_val <= b;
    repeat (4) @(posedge clock);
    mdc <= 1'b1;
    repeat (4) @(posedge clock);
    s = mdio_in;
    mdc <= 1'b0;
  endtask
  // mdc stays low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, op, phy, ra};
    for (int i = 0; i < 32; i++)
      bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      bit_cycle(1'b1, hdr[i], s);
    bit_cycle(op == op_write, 1'b1, s);
    bit_cycle(op == op_write, 1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      bit_cycle(op == op_write, wd[i], s);
      rd[i] = s;
    end
    st_oe <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
endmodule

// ---- bench/phy_mgmt_regs_tb_top.sv ----
`timescale 1ns/100ps
module phy_mgmt_regs_tb_top;
  import mgmt_regs_pkg::*;
  localparam logic [4:0] my_phy = 5'h05;
  logic clock, rst_b, mdc, mdio_in, mdio_out, mdio_oe, sgmii_sel, copper_sel, link_qualified, mirror_mode;
  logic [1:0] crossover_strap, op_speed;
  logic [4:0] ext_dev;
  logic [15:0] ext_addr, ext_wdata, ext_rdata;
  logic ext_wr, ext_rd, tx_fifo_enable, rx_fifo_enable, link_good, active_sleep, passive_sleep;
  logic [3:0] tx_fifo_depth, rx_fifo_depth;
  logic force_mdi, force_mdix, auto_crossover, ref_clock_output, line_drive_invert, jabber_enable;
  int fail_count, comparisons, wr_n, rd_n, oe_n;
  logic [36:0] wr_rec;
  logic [20:0] rd_rec;

  phy_mgmt_regs #(.phy_addr(my_phy)) phy_mgmt_regs_inst (
    .clock, .rst_b, .mdc, .mdio_in, .mdio_out, .mdio_oe, .crossover_strap, .op_speed, .sgmii_sel,
    .copper_sel, .link_qualified, .mirror_mode, .ext_dev, .ext_addr, .ext_wdata, .ext_wr, .ext_rd,
    .ext_rdata, .tx_fifo_enable, .tx_fifo_depth, .rx_fifo_enable, .rx_fifo_depth, .link_good,
    .active_sleep, .passive_sleep, .force_mdi, .force_mdix, .auto_crossover, .ref_clock_output,
    .line_drive_invert, .jabber_enable);
  mdio_station mdio_station_inst (.clock, .mdc, .mdio_in, .mdio_out, .mdio_oe);

  // extended register file answers with a pattern tied to device and address
  function automatic logic [15:0] xd(input logic [4:0] d, input logic [15:0] a);
    return {d, 11'h000} ^ a ^ 16'h3c5a;
  endfunction
  assign ext_rdata = xd(ext_dev, ext_addr);

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    if (ext_wr === 1'b1)
    begin
      wr_n++;
      wr_rec = {ext_dev, ext_addr, ext_wdata};
    end
    if (ext_rd === 1'b1)
    begin
      rd_n++;
      rd_rec = {ext_dev, ext_addr};
    end
    if (mdio_oe === 1'b1)
      oe_n++;
  end

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [36:0] seen, input logic [36:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    mdio_station_inst.frame(op_write, my_phy, ra, d, x);
  endtask
  task automatic rchk(input string what, input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    mdio_station_inst.frame(op_read, my_phy, ra, 16'h0000, v);
    chk(what, v, exp);
  endtask
  task automatic wwin(input logic [4:0] d, input logic [15:0] a, input logic [15:0] v);
    int n0;
    n0 = wr_n;
    wr(off_window, v);
    chk("ext write count", 37'(wr_n - n0), 37'd1);
    chk("ext write", wr_rec, {d, a, v});
  endtask
  task automatic rwin(input logic [4:0] d, input logic [15:0] a);
    int n0;
    n0 = rd_n;
    rchk("window data", off_window, xd(d, a));
    chk("ext read count", 37'(rd_n - n0), 37'd1);
    chk("ext read", 37'(rd_rec), {16'h0000, d, a});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rchk("access control", off_access_control, 16'h0000);
    rchk("capability", off_capability, 16'hf000);
    wr(off_capability, 16'h0000);
    rchk("capability kept", off_capability, 16'hf000);
    rchk("general control", off_general_control, 16'h5048);
    rchk("unmapped", 5'h11, 16'h0000);
    chk("depths", {tx_fifo_depth, rx_fifo_depth}, 37'h44);
    chk("decodes", {auto_crossover, force_mdi, force_mdix, ref_clock_output, jabber_enable}, 37'h13);
    $display("test reset done");
  endtask

  task automatic t_window;
    int n0;
    // vendor set chosen before window use
    wr(off_access_control, {func_address, 9'h000, vendor_mmd});
    wr(off_window, 16'h0100);
    wr(off_access_control, 16'hffff);
    rchk("reserved bits", off_access_control, 16'hc01f);
    wr(off_access_control, {func_data, 9'h000, vendor_mmd});
    wwin(vendor_mmd, 16'h0100, 16'hbeef);
    rwin(vendor_mmd, 16'h0100);
    rwin(vendor_mmd, 16'h0100);
    wr(off_access_control, {func_inc_rw, 9'h000, vendor_mmd});
    rwin(vendor_mmd, 16'h0100);
    rwin(vendor_mmd, 16'h0101);
    wwin(vendor_mmd, 16'h0102, 16'h0001);
    rwin(vendor_mmd, 16'h0103);
    wr(off_access_control, {func_inc_wr, 9'h000, vendor_mmd});
    rwin(vendor_mmd, 16'h0104);
    rwin(vendor_mmd, 16'h0104);
    wwin(vendor_mmd, 16'h0104, 16'h8000);
    wr(off_access_control, {func_address, 9'h000, vendor_mmd});
    n0 = rd_n;
    rchk("stored address", off_window, 16'h0105);
    wr(off_access_control, 16'h0003);
    n0 = n0 + wr_n;
    wr(off_window, 16'h0077);
    chk("address only", 37'(rd_n + wr_n - n0), 37'd0);
    wr(off_access_control, 16'h4003);
    wwin(5'h03, 16'h0077, 16'h1234);
    wr(off_access_control, {func_data, 9'h000, vendor_mmd});
    rwin(vendor_mmd, 16'h0105);
    $display("test window done");
  endtask

  task automatic t_control;
    logic [15:0] cw [4] = '{16'h0000, 16'ha733, 16'hf2c0, 16'h5160};
    logic [7:0] dp [4] = '{8'h33, 8'h66, 8'h88, 8'h44};
    logic [8:0] fl [4] = '{9'h0b0, 9'h04b, 9'h134, 9'h130};
    logic [5:0] fe [4] = '{6'h2a, 6'h33, 6'h19, 6'h24};
    for (int i = 0; i < 4; i++)
    begin
      wr(off_general_control, cw[i]);
      rchk("control readback", off_general_control, cw[i]);
      chk("depths", {tx_fifo_depth, rx_fifo_depth}, 37'(dp[i]));
      chk("decodes", {auto_crossover, force_mdi, force_mdix, ref_clock_output, jabber_enable,
          line_drive_invert, active_sleep, passive_sleep, link_good}, 37'(fl[i]));
    end
    // fifo activity against medium and interface
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      {copper_sel, sgmii_sel, op_speed} <= fe[i][5:2];
      repeat (3) @(posedge clock);
      chk("fifo enables", {tx_fifo_enable, rx_fifo_enable}, 37'(fe[i][1:0]));
    end
    wr(off_general_control, 16'ha733);
    chk("forced link slow", link_good, 1'b0);
    @(posedge clock);
    link_qualified <= 1'b1;
    repeat (3) @(posedge clock);
    chk("normal link", link_good, 1'b1);
    @(posedge clock);
    link_qualified <= 1'b0;
    op_speed <= speed_1g;
    mirror_mode <= 1'b1;
    repeat (3) @(posedge clock);
    chk("forced link", link_good, 1'b1);
    chk("invert in mirror", line_drive_invert, 1'b0);
    $display("test control done");
  endtask

  task automatic t_refuse;
    logic [15:0] x;
    int n0;
    n0 = oe_n;
    mdio_station_inst.frame(op_write, my_phy ^ 5'h01, off_general_control, 16'h0000, x);
    mdio_station_inst.frame(2'h3, my_phy, off_general_control, 16'h0000, x);
    mdio_station_inst.frame(op_read, my_phy ^ 5'h10, off_general_control, 16'h0000, x);
    chk("no drive", 37'(oe_n - n0), 37'd0);
    rchk("control kept", off_general_control, 16'ha733);
    chk("jabber off", jabber_enable, 1'b0);
    $display("test refuse done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    rst_b = 1'b0;
    crossover_strap = 2'h2;
    op_speed = speed_1g;
    sgmii_sel = 1'b0;
    copper_sel = 1'b1;
    link_qualified = 1'b0;
    mirror_mode = 1'b0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (10) @(posedge clock);
    t_reset;
    t_window;
    t_control;
    t_refuse;
    finish_test;
  end
  // 44 frames of some 520 clocks each
  initial
  begin
    repeat (80000) @(posedge clock);
    fail_count++;
    $display("watchdog expired");
    finish_test;
  end
endmodule
